// ### lpmc_top.sv
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/1ps
module lpmc_top import lpmc_pkg::*; #(
	parameter int WU_SHR = 0
) (
	// Clock and reset
	input  wire logic              CLK_I,
	input  wire logic              ARST_N_I,
	// Register port
	input  wire lpmc_bus_t         BUS_I,
	output logic [DATA_W-1:0]      RDATA_O,
	// Pins and oscillator taps
	input  wire logic              STOP_PIN_I,
	input  wire logic [KEY_W-1:0]  KEY_WAKE_I,
	input  wire logic [7:0]        TB_SRC_I,
	input  wire logic              LF_CLK_I,
	// Interrupt controller
	input  wire logic [7:0]        IRQ_PEND_I,
	input  wire logic [7:0]        IRQ_EN_I,
	input  wire logic              IMF_I,
	input  wire logic              TBT_IRQ_EN_I,
	input  wire logic              WDT_IRQ_I,
	// Mode outputs
	output logic                   CPU_HALT_O,
	output logic                   WDT_HALT_O,
	output logic                   PC_HOLD_O,
	output logic                   PERIPH_CLK_EN_O,
	output logic                   TBT_CLK_EN_O,
	output logic                   XEN_O,
	output logic                   XTEN_O,
	output logic                   SLOW_O,
	output logic                   DIV_CLR_O,
	output logic                   RESUME_O,
	output logic                   SERVICE_O,
	output logic                   TBT_LATCH_SET_O
);
	typedef struct packed {
		lpmc_mode_t        mode;
		logic [7:0]        ctrl1;
		logic [7:0]        ctrl2;
		logic [7:0]        tbc;
		logic [KEY_W-1:0]  keym;
		logic              rel_eff;
		logic              stop_s1;
		logic              stop_s2;
		logic              stop_prev;
		logic [KEY_W-1:0]  key_s1;
		logic [KEY_W-1:0]  key_s2;
		logic [7:0]        tb_s1;
		logic [7:0]        tb_s2;
		logic              tb_prev;
		logic              lf_s1;
		logic              lf_s2;
		logic              lf_prev;
		logic [DIV_W-1:0]  div;
		logic              tb_armed;
		logic [DATA_W-1:0] rdata;
		logic              cpu_halt;
		logic              periph_en;
		logic              tbt_en;
		logic              xen;
		logic              xten;
		logic              div_clr;
		logic              resume;
		logic              service;
		logic              tbt_set;
	} lpmc_state_t;

	lpmc_state_t q;
	lpmc_state_t d;
	logic        rst_s1;
	logic        rst_n;
	logic        stop_rise;
	logic        tb_sel;
	logic        tb_fall;
	logic        lf_rise;
	logic        lvl_rel;
	logic        irq_hit;

	// The WU_SHR shift only exists to shorten warm-up in simulation
	function automatic logic [DIV_W-1:0] wu_target(input logic [2:0] sel, input logic slow);
		logic [DIV_W-1:0] t;
		t = '0;
		casez (sel)
			3'b000:  t = slow ? WU_S_000 : WU_F_000;
			3'b010:  t = slow ? WU_S_010 : WU_F_010;
			3'b100:  t = slow ? WU_S_100 : WU_F_100;
			3'b110:  t = slow ? WU_S_110 : WU_F_110;
			3'b?01:  t = slow ? WU_S_X01 : WU_F_X01;
			default: t = slow ? WU_S_X11 : WU_F_X11;
		endcase
		return t >> WU_SHR;
	endfunction

	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			rst_s1 <= 1'b0;
			rst_n  <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_n  <= rst_s1;
		end
	end

	assign stop_rise = q.stop_s2 & ~q.stop_prev;
	assign tb_sel    = q.tb_s2[q.tbc[2:0]];
	assign tb_fall   = q.tb_prev & ~tb_sel;
	assign lf_rise   = q.lf_s2 & ~q.lf_prev;
	assign lvl_rel   = q.stop_s2 | (|(~q.key_s2 & q.keym));
	assign irq_hit   = |(IRQ_PEND_I & IRQ_EN_I);

	always_comb begin
		d = q;
		d.stop_s1   = STOP_PIN_I;
		d.stop_s2   = q.stop_s1;
		d.stop_prev = q.stop_s2;
		d.key_s1    = KEY_WAKE_I;
		d.key_s2    = q.key_s1;
		d.tb_s1     = TB_SRC_I;
		d.tb_s2     = q.tb_s1;
		d.tb_prev   = tb_sel;
		d.lf_s1     = LF_CLK_I;
		d.lf_s2     = q.lf_s1;
		d.lf_prev   = q.lf_s2;
		d.resume    = 1'b0;
		d.service   = 1'b0;
		d.tbt_set   = 1'b0;
		// Level mode is granted only once the pin has shown a rising edge
		if (!q.ctrl1[C1_STOP_RELEASE_SELECT])
			d.rel_eff = 1'b0;
		else if (stop_rise)
			d.rel_eff = 1'b1;
		d.rdata = '0;
		if (BUS_I.re) begin
			case (BUS_I.addr)
				OFF_CTRL1: d.rdata = q.ctrl1;
				OFF_CTRL2: d.rdata = q.ctrl2;
				OFF_TBC:   d.rdata = q.tbc;
				OFF_KEYM:  d.rdata = {4'h0, q.keym};
				OFF_STAT:  d.rdata = {3'h0, q.rel_eff, q.stop_s2, q.mode};
				default:   d.rdata = '0;
			endcase
		end
		if (BUS_I.we && q.mode == ST_RUN) begin
			case (BUS_I.addr)
				OFF_CTRL1: d.ctrl1 = BUS_I.wdata;
				OFF_CTRL2: begin
					d.ctrl2 = BUS_I.wdata;
					// A pending watchdog interrupt wins over halt entry
					if (WDT_IRQ_I) begin
						d.ctrl2[C2_IDLE] = 1'b0;
						d.ctrl2[C2_TGH]  = 1'b0;
					end
				end
				OFF_TBC:   d.tbc = BUS_I.wdata;
				OFF_KEYM:  d.keym = BUS_I.wdata[KEY_W-1:0];
				default:   d.tbc = q.tbc;
			endcase
		end
		case (q.mode)
			ST_RUN: begin
				if (q.ctrl1[C1_STOP]) begin
					d.div = '0;
					if (q.rel_eff && lvl_rel)
						d.mode = ST_WARM;
					else
						d.mode = ST_STOP;
				end else if (q.ctrl2[C2_IDLE]) begin
					d.mode = ST_CHALT;
				end else if (q.ctrl2[C2_TGH]) begin
					d.mode     = ST_GHALT;
					d.tb_armed = q.tbc[TB_EN];
				end
			end
			ST_STOP: begin
				d.div = '0;
				if (q.rel_eff ? lvl_rel : stop_rise) begin
					d.mode = ST_WARM;
					d.ctrl2[C2_SCK] = q.ctrl1[C1_RETM];
					if (q.ctrl1[C1_RETM]) begin
						d.ctrl2[C2_XEN]  = 1'b0;
						d.ctrl2[C2_XTEN] = 1'b1;
					end else begin
						d.ctrl2[C2_XEN] = 1'b1;
					end
				end
			end
			ST_WARM: begin
				// Slow return counts low-frequency edges; fast return counts every clock
				if (!q.ctrl1[C1_RETM] || lf_rise)
					d.div = q.div + 1'b1;
				if (q.div >= wu_target(q.ctrl1[2:0], q.ctrl1[C1_RETM])) begin
					d.mode           = ST_RUN;
					d.ctrl1[C1_STOP] = 1'b0;
					d.resume         = 1'b1;
				end
			end
			ST_CHALT: begin
				if (irq_hit) begin
					d.mode           = ST_RUN;
					d.ctrl2[C2_IDLE] = 1'b0;
					d.resume         = 1'b1;
					d.service        = IMF_I;
				end
			end
			ST_GHALT: begin
				if (tb_fall) begin
					d.mode          = ST_RUN;
					d.ctrl2[C2_TGH] = 1'b0;
					d.resume        = 1'b1;
					d.tbt_set       = q.tb_armed;
					d.service       = IMF_I & TBT_IRQ_EN_I & q.tbc[TB_EN];
				end
			end
			default: d.mode = ST_RUN;
		endcase
		// The core is held in every halt, peripherals still run in ST_CHALT; the core only sees cpu_halt
		d.cpu_halt  = d.mode != ST_RUN;
		d.periph_en = d.mode == ST_RUN || d.mode == ST_CHALT;
		d.tbt_en    = d.periph_en || d.mode == ST_GHALT;
		d.xen       = d.mode != ST_STOP && d.ctrl2[C2_XEN];
		d.xten      = d.mode != ST_STOP && d.ctrl2[C2_XTEN];
		d.div_clr   = d.mode == ST_STOP;
	end

	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			q       <= '0;
			q.mode  <= ST_RUN;
			q.ctrl1 <= CTRL1_RST;
			q.ctrl2 <= CTRL2_RST;
			q.periph_en <= 1'b1;
			q.tbt_en    <= 1'b1;
			q.xen       <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign RDATA_O         = q.rdata;
	assign CPU_HALT_O      = q.cpu_halt;
	assign WDT_HALT_O      = q.cpu_halt;
	assign PC_HOLD_O       = q.cpu_halt;
	assign PERIPH_CLK_EN_O = q.periph_en;
	assign TBT_CLK_EN_O    = q.tbt_en;
	assign XEN_O           = q.xen;
	assign XTEN_O          = q.xten;
	assign SLOW_O          = q.ctrl2[C2_SCK];
	assign DIV_CLR_O       = q.div_clr;
	assign RESUME_O        = q.resume;
	assign SERVICE_O       = q.service;
	assign TBT_LATCH_SET_O = q.tbt_set;

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!rst_n);

	sequence s_stop_edge;
		q.mode == ST_STOP && !q.rel_eff && stop_rise;
	endsequence
	sequence s_warm_done;
		q.mode == ST_WARM ##1 q.mode == ST_RUN;
	endsequence
	sequence s_chalt_hit;
		q.mode == ST_CHALT && irq_hit;
	endsequence

	chk_edge_release: assert property (s_stop_edge |=> q.mode == ST_WARM)
		else $error("edge release missed");
	chk_edge_entry: assert property (q.mode == ST_RUN && q.ctrl1[C1_STOP] && !q.rel_eff
		|=> q.mode == ST_STOP)
		else $error("edge mode STOP entry missed");
	chk_no_restop: assert property (q.mode == ST_WARM |=> q.mode != ST_STOP)
		else $error("STOP re-entered in warm-up");
	chk_rel_hold: assert property (!q.rel_eff && !stop_rise |=> !q.rel_eff)
		else $error("level mode taken without edge");
	chk_osc_slow: assert property (q.mode == ST_STOP ##1 q.mode == ST_WARM
		&& q.ctrl1[C1_RETM] |-> q.xten && !q.xen)
		else $error("slow return oscillators wrong");
	chk_warm_halt: assert property (q.mode == ST_WARM |-> q.cpu_halt && !q.periph_en)
		else $error("activity during warm-up");
	chk_warm_resume: assert property (s_warm_done |-> q.resume && !q.ctrl1[C1_STOP])
		else $error("no resume after warm-up");
	chk_div_clear: assert property (q.mode == ST_STOP |-> q.div == '0 && q.div_clr)
		else $error("divider not cleared");
	chk_chalt_run: assert property (q.mode == ST_CHALT |-> q.periph_en && q.cpu_halt)
		else $error("core halt gating wrong");
	chk_chalt_exit: assert property (s_chalt_hit |=> q.mode == ST_RUN
		&& !q.ctrl2[C2_IDLE] && q.service == $past(IMF_I))
		else $error("core halt release wrong");
	chk_wdt_block: assert property (q.mode == ST_RUN && BUS_I.we
		&& BUS_I.addr == OFF_CTRL2 && WDT_IRQ_I |=> !q.ctrl2[C2_IDLE] ##1 q.mode != ST_CHALT)
		else $error("halt entered despite watchdog irq");
	chk_ghalt_gate: assert property (q.mode == ST_GHALT |-> !q.periph_en && q.tbt_en)
		else $error("gated halt clocks wrong");
	chk_ghalt_exit: assert property (q.mode == ST_GHALT && tb_fall |=> q.mode == ST_RUN
		&& q.resume && !q.ctrl2[C2_TGH] && q.tbt_set == $past(q.tb_armed))
		else $error("gated halt release wrong");

	// Remaining wake, hold, count, oscillator and register paths
	sequence s_stop_exit;
		q.mode == ST_STOP ##1 q.mode == ST_WARM;
	endsequence

	sequence s_level_wake;
		q.mode == ST_STOP && q.rel_eff && lvl_rel;
	endsequence

	sequence s_ghalt_hit;
		q.mode == ST_GHALT && tb_fall;
	endsequence

	chk_osc_fast: assert property (s_stop_exit ##0 !q.ctrl1[C1_RETM]
		|-> q.xen)
		else $error("fast return oscillator off");

	chk_stop_osc: assert property (q.mode == ST_STOP
		|-> !q.xen && !q.xten)
		else $error("oscillator running in STOP");

	chk_level_wake: assert property (s_level_wake
		|=> q.mode == ST_WARM)
		else $error("level release missed");

	chk_level_entry: assert property (q.mode == ST_RUN && q.ctrl1[C1_STOP]
		&& q.rel_eff && lvl_rel |=> q.mode == ST_WARM)
		else $error("level entry did not skip STOP");

	chk_stop_hold: assert property (q.mode == ST_STOP && !q.rel_eff && !stop_rise
		|=> q.mode == ST_STOP)
		else $error("STOP left without an edge");

	chk_warm_count: assert property (q.mode == ST_WARM
		&& q.div < wu_target(q.ctrl1[2:0], q.ctrl1[C1_RETM]) |=> q.mode == ST_WARM)
		else $error("warm-up ended early");

	chk_warm_step: assert property (q.mode == ST_WARM && !q.ctrl1[C1_RETM]
		&& q.div < wu_target(q.ctrl1[2:0], 1'b0) |=> q.div == $past(q.div) + 18'h00001)
		else $error("fast warm-up count stalled");

	chk_div_start: assert property (s_stop_exit
		|-> q.div == '0)
		else $error("warm-up did not start cleared");

	chk_chalt_hold: assert property (q.mode == ST_CHALT && !irq_hit
		|=> q.mode == ST_CHALT)
		else $error("core halt left without wake");

	chk_ghalt_hold: assert property (q.mode == ST_GHALT && !tb_fall
		|=> q.mode == ST_GHALT)
		else $error("gated halt left without edge");

	chk_chalt_wake: assert property (s_chalt_hit
		|=> q.resume && !q.cpu_halt)
		else $error("core halt wake pulse missing");

	chk_ghalt_service: assert property (s_ghalt_hit
		|=> q.service == ($past(IMF_I) && $past(TBT_IRQ_EN_I) && $past(q.tbc[TB_EN])))
		else $error("gated halt service wrong");

	chk_gated_armed: assert property (q.mode == ST_RUN && q.ctrl2[C2_TGH]
		&& !q.ctrl1[C1_STOP] && !q.ctrl2[C2_IDLE] |=> q.tb_armed == $past(q.tbc[TB_EN]))
		else $error("time base latch arm wrong");

	chk_resume_pulse: assert property (q.resume
		|=> !q.resume)
		else $error("resume pulse too long");

	chk_rel_clear: assert property (!q.ctrl1[C1_STOP_RELEASE_SELECT]
		|=> !q.rel_eff)
		else $error("level mode kept after edge select");

	chk_write_lock: assert property (q.mode != ST_RUN && BUS_I.we
		&& BUS_I.addr == OFF_TBC |=> $stable(q.tbc))
		else $error("register written while halted");

	chk_rdata_idle: assert property (!$past(BUS_I.re)
		|-> q.rdata == '0)
		else $error("read data outside its cycle");
endmodule

// ### lpmc_pkg.sv
// Behaviour
// - Edge release mode leaves STOP on a rising stop pin edge.
// - Edge release mode enters STOP even while the stop pin is high.
// - Level mode: a low stop pin during warm-up never re-enters STOP.
// - Edge to level change takes effect only after a stop pin rising edge.
// - STOP release enables oscillators by clock mode and return target.
// - After STOP release a warm-up runs with all operations halted.
// - Warm-up select picks one of six durations: 000,010,100,110,*01,*11.
// - After warm-up execution resumes at the instruction after STOP entry.
// - Prescaler and timing generator divider are cleared before restart.
// - Reset pin low ends STOP at once with the normal reset sequence.
// - Core halt stops CPU and watchdog; peripherals keep running.
// - In any halt the program counter and all state are held.
// - Core halt release clears cpu_halt_bit and restores the prior mode.
// - Reset pin low releases any halt; operation restarts fast_clock_single.
// - Master enable 0: enabled interrupt ends core halt without service.
// - Master enable 1: enabled interrupt ends core halt and is serviced.
// - A watchdog interrupt just before halt entry blocks the halt.
// - Gated halt stops clocks to all peripherals except the time base.
// - Gated halt release clears its bit; latch set if time base enabled.
// - Product 0: time base source falling edge ends gated halt, no service.
// - Product 1: the falling edge ends gated halt and services the irq.
// - Level mode releases on stop pin high or enabled key input low.
// - Fast return codes 010 and 110 give 2^16 and 2^14 clocks.
package lpmc_pkg;
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;
	localparam int KEY_W  = 4;
	localparam int DIV_W  = 18;
	localparam logic [2:0] OFF_CTRL1 = 3'h0;
	localparam logic [2:0] OFF_CTRL2 = 3'h1;
	localparam logic [2:0] OFF_TBC   = 3'h2;
	localparam logic [2:0] OFF_KEYM  = 3'h3;
	localparam logic [2:0] OFF_STAT  = 3'h4;
	localparam int C1_STOP = 7;
	localparam int C1_STOP_RELEASE_SELECT = 6;
	localparam int C1_RETM = 5;
	localparam int C2_XEN  = 7;
	localparam int C2_XTEN = 6;
	localparam int C2_SCK  = 5;
	localparam int C2_IDLE = 4;
	localparam int C2_TGH  = 2;
	localparam int TB_EN   = 3;
	localparam logic [7:0] CTRL1_RST = 8'h00;
	localparam logic [7:0] CTRL2_RST = 8'h80;
	localparam logic [DIV_W-1:0] WU_F_000 = 18'h30000;
	localparam logic [DIV_W-1:0] WU_F_010 = 18'h10000;
	localparam logic [DIV_W-1:0] WU_F_100 = 18'h0C000;
	localparam logic [DIV_W-1:0] WU_F_110 = 18'h04000;
	localparam logic [DIV_W-1:0] WU_F_X01 = 18'h00C00;
	localparam logic [DIV_W-1:0] WU_F_X11 = 18'h00400;
	localparam logic [DIV_W-1:0] WU_S_000 = 18'h06000;
	localparam logic [DIV_W-1:0] WU_S_010 = 18'h02000;
	localparam logic [DIV_W-1:0] WU_S_100 = 18'h000C0;
	localparam logic [DIV_W-1:0] WU_S_110 = 18'h00040;
	localparam logic [DIV_W-1:0] WU_S_X01 = 18'h000C0;
	localparam logic [DIV_W-1:0] WU_S_X11 = 18'h00040;
	typedef enum logic [2:0] {ST_RUN, ST_STOP, ST_WARM, ST_CHALT, ST_GHALT} lpmc_mode_t;
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              we;
		logic              re;
	} lpmc_bus_t;
endpackage

// ### lpmc_far_model.sv
`timescale 1ns/1ps
module lpmc_far_model (
	// Clock
	input  wire logic       clk_i,
	// Control from the bench
	input  wire logic       stop_lvl_i,
	input  wire logic       tb_run_i,
	// Pins toward the block
	output logic            stop_pin_o,
	output logic [7:0]      tb_src_o,
	output logic            lf_clk_o
);
	logic [4:0] div_q = 5'h00;
	logic       lf_q  = 1'b0;

	// The time base tap only moves while asked, so a halt never ends by accident
	always @(posedge clk_i) begin
		if (tb_run_i) begin
			div_q <= div_q + 5'h01;
		end
		lf_q <= ~lf_q;
	end

	assign lf_clk_o   = lf_q;

	assign stop_pin_o = stop_lvl_i;
	assign tb_src_o   = {3'h0, div_q};
endmodule

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top import lpmc_pkg::*;;
	logic            clk = 1'b0;
	logic            arst_n = 1'b0;
	lpmc_bus_t       bus = '0;
	logic [7:0]      rdata;
	logic            stop_lvl = 1'b1;
	logic            tb_run = 1'b0;
	logic            stop_pin;
	logic [7:0]      tb_src;
	logic            lf_clk;
	logic [7:0]      irq_pend = 8'h00;
	logic [7:0]      irq_en = 8'h00;
	logic            master_irq_enable = 1'b0;
	logic            tbt_en = 1'b0;
	logic            wdt_irq = 1'b0;
	logic [3:0]      key = 4'hF;
	logic            cpu_halt, wdt_halt, pc_hold, periph_en, tbt_clk_en;
	logic            xen, xten, slow, div_clr, resume, service, tbt_set;
	int              n_mismatch = 0;
	int              compares = 0;
	logic [7:0]      rd;

	always #5 clk = ~clk;

	lpmc_far_model far_u (.clk_i(clk), .stop_lvl_i(stop_lvl), .tb_run_i(tb_run),
		.stop_pin_o(stop_pin), .tb_src_o(tb_src), .lf_clk_o(lf_clk));

	lpmc_top #(.WU_SHR(8)) dut_u (.CLK_I(clk), .ARST_N_I(arst_n), .BUS_I(bus),
		.RDATA_O(rdata), .STOP_PIN_I(stop_pin), .KEY_WAKE_I(key), .TB_SRC_I(tb_src),
		.LF_CLK_I(lf_clk), .IRQ_PEND_I(irq_pend), .IRQ_EN_I(irq_en), .IMF_I(master_irq_enable),
		.TBT_IRQ_EN_I(tbt_en), .WDT_IRQ_I(wdt_irq), .CPU_HALT_O(cpu_halt),
		.WDT_HALT_O(wdt_halt), .PC_HOLD_O(pc_hold), .PERIPH_CLK_EN_O(periph_en),
		.TBT_CLK_EN_O(tbt_clk_en), .XEN_O(xen), .XTEN_O(xten), .SLOW_O(slow),
		.DIV_CLR_O(div_clr), .RESUME_O(resume), .SERVICE_O(service),
		.TBT_LATCH_SET_O(tbt_set));

	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
		@(posedge clk);
		bus.we <= 1'b0;
	endtask

	task automatic rdr(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
		@(posedge clk);
		bus.re <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask

	// Waits for the release pulse, then samples the companions in the same cycle
	task automatic wait_resume(input int bound);
		int i;
		for (i = 0; i < bound; i++) begin
			@(negedge clk);
			if (resume === 1'b1) begin
				return;
			end
		end
		n_mismatch++;
		$display("Error resume pulse expected 1 seen 0");
		complete_run();
	endtask

	task automatic t_reset_regs();
		rdr(OFF_CTRL2, rd);
		chk("ctrl2 reset", rd, CTRL2_RST);
		rdr(3'h6, rd);
		chk("unmapped read", rd, 8'h00);
		chk("periph clock", {7'h0, periph_en}, 8'h01);
	endtask

	task automatic t_stop_edge();
		wr(OFF_CTRL1, 8'h83);
		repeat (3) @(negedge clk);
		chk("xen in stop", {7'h0, xen}, 8'h00);
		chk("divider clear", {7'h0, div_clr}, 8'h01);
		chk("cpu halt stop", {7'h0, cpu_halt}, 8'h01);
		repeat (6) @(negedge clk);
		chk("still stopped", {7'h0, cpu_halt}, 8'h01);
		@(posedge clk);
		stop_lvl <= 1'b0;
		repeat (6) @(posedge clk);
		stop_lvl <= 1'b1;
		wait_resume(60);
		chk("xen after stop", {7'h0, xen}, 8'h01);
		chk("xten after stop", {7'h0, xten}, 8'h00);
		@(negedge clk);
		chk("run after warm", {7'h0, pc_hold}, 8'h00);
		rdr(OFF_CTRL1, rd);
		chk("stop bit clear", rd & 8'h80, 8'h00);
	endtask

	task automatic t_core_halt(input logic m);
		@(posedge clk);
		master_irq_enable <= 1'b0;
		irq_en <= 8'h01;
		wr(OFF_CTRL2, 8'h90);
		master_irq_enable <= m;
		repeat (3) @(negedge clk);
		chk("core halt cpu", {7'h0, cpu_halt}, 8'h01);
		chk("core halt wdt", {7'h0, wdt_halt}, 8'h01);
		chk("core halt periph", {7'h0, periph_en}, 8'h01);
		chk("core halt pc", {7'h0, pc_hold}, 8'h01);
		@(posedge clk);
		irq_pend <= 8'h01;
		wait_resume(20);
		chk("core service", {7'h0, service}, {7'h0, m});
		@(posedge clk);
		irq_pend <= 8'h00;
		master_irq_enable <= 1'b0;
		rdr(OFF_CTRL2, rd);
		chk("halt bit clear", rd, 8'h80);
	endtask

	task automatic t_wdt_block();
		@(posedge clk);
		wdt_irq <= 1'b1;
		wr(OFF_CTRL2, 8'h90);
		repeat (3) @(negedge clk);
		chk("wdt blocks halt", {7'h0, cpu_halt}, 8'h00);
		@(posedge clk);
		wdt_irq <= 1'b0;
		rdr(OFF_CTRL2, rd);
		chk("wdt halt bit", rd & 8'h10, 8'h00);
	endtask

	task automatic t_gated();
		@(posedge clk);
		master_irq_enable <= 1'b1;
		tbt_en <= 1'b1;
		wr(OFF_TBC, 8'h08);
		// TB_EN is set here, so the time base latch is armed for the gated halt release
		wr(OFF_CTRL2, 8'h84);
		repeat (3) @(negedge clk);
		chk("gated periph", {7'h0, periph_en}, 8'h00);
		chk("gated time base", {7'h0, tbt_clk_en}, 8'h01);
		@(posedge clk);
		tb_run <= 1'b1;
		wait_resume(100);
		chk("gated service", {7'h0, service}, 8'h01);
		chk("latch set", {7'h0, tbt_set}, 8'h01);
		@(posedge clk);
		tb_run <= 1'b0;
		master_irq_enable <= 1'b0;
		rdr(OFF_CTRL2, rd);
		chk("gated bit clear", rd, 8'h80);
	endtask

	task automatic t_reset_stop();
		wr(OFF_CTRL1, 8'h83);
		repeat (3) @(negedge clk);
		chk("stop before reset", {7'h0, cpu_halt}, 8'h01);
		@(posedge clk);
		arst_n <= 1'b0;
		@(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		@(negedge clk);
		chk("reset ends stop", {7'h0, cpu_halt}, 8'h00);
		chk("reset xen", {7'h0, xen}, 8'h01);
		rdr(OFF_CTRL1, rd);
		chk("reset ctrl1", rd, CTRL1_RST);
		rdr(OFF_CTRL2, rd);
		chk("reset ctrl2", rd, CTRL2_RST);
	endtask

	task automatic t_stop_level();
		wr(OFF_KEYM, 8'h01);
		wr(OFF_CTRL1, 8'h43);
		rdr(OFF_STAT, rd);
		chk("level held off", rd, 8'h08);
		@(posedge clk);
		stop_lvl <= 1'b0;
		repeat (4) @(posedge clk);
		stop_lvl <= 1'b1;
		repeat (4) @(posedge clk);
		rdr(OFF_STAT, rd);
		chk("level granted", rd, 8'h18);
		@(posedge clk);
		stop_lvl <= 1'b0;
		repeat (4) @(posedge clk);
		wr(OFF_CTRL1, 8'hE3);
		repeat (3) @(negedge clk);
		chk("level stopped", {7'h0, cpu_halt}, 8'h01);
		@(posedge clk);
		key <= 4'hE;
		wait_resume(40);
		chk("slow xen", {7'h0, xen}, 8'h00);
		chk("slow xten", {7'h0, xten}, 8'h01);
		chk("slow select", {7'h0, slow}, 8'h01);
		// Key still low: entry must go straight to warm-up and end quickly
		wr(OFF_CTRL1, 8'hE3);
		wait_resume(3);
		@(posedge clk);
		key <= 4'hF;
	endtask

	initial begin
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		t_reset_regs();
		t_stop_edge();
		t_core_halt(1'b0);
		t_core_halt(1'b1);
		t_wdt_block();
		t_gated();
		t_reset_stop();
		t_stop_level();
		complete_run();
	end
endmodule
